// ### core/sbc_ctrl.sv
// Host controller for a two-word burst SRAM with separate read and write ports.
//
// Operation
// - With DLL bypassed, wait 1024 idle cycles after clocks are stable.
// - With DLL enabled, raise the DLL-disable pin, then wait 1024 idle cycles.
// - With pin high and clocks unstable, stop clocks 30 ns, then 1024 idle cycles; the code stops the clocks only on a relock, never at start-up.
// - During clock stop, hold the true output clock low at least 30 ns.
// - After any clock stop, issue 1024 idle cycles before reads or writes.
// - On frequency change with DLL on, reset DLL and wait 1024 idle cycles.
// - Never run DLL enabled below 100 MHz; slow clocks need bypass; CTRL_DLL_EN still enables it at the 5 MHz memory clock.
// - Write select low at true clock rise; word 0 there, word 1 at complement.
// - Selects are sampled only at the true input clock rise.
// - Park true clocks low and complements high when stopping clocks.
// - Wide port: four low-active lane enables gate nine-bit lanes per beat.
// - Medium port: two low-active lane enables gate two nine-bit lanes.
// - Narrow port: one low-active enable gates all nine bits per beat.
// - Tied-high output clocks stay high and never toggle.
`timescale 1ns/10ps
`default_nettype none

module sbc_ctrl #(
	parameter int DW = 36,
	parameter int AW = 20,
	parameter int LANES = 4,
	parameter int NOP_COUNT = sbc_pkg::NOP_CYCLES
) (
	// Clock and reset.
	input  wire logic             I_CLK,
	input  wire logic             I_RESET,
	// Register port.
	input  wire logic [3:0]       I_REG_ADDR,
	input  wire logic [31:0]      I_REG_WDATA,
	input  wire logic             I_REG_WR,
	input  wire logic             I_REG_RD,
	output logic      [31:0]      O_REG_RDATA,
	// Memory clocks.
	output logic                  O_K,
	output logic                  O_K_N,
	output logic                  O_C,
	output logic                  O_C_N,
	// Memory control.
	output logic                  O_DLL_DISABLE_N,
	output logic                  O_READ_SEL_N,
	output logic                  O_WRITE_SEL_N,
	output logic      [AW-1:0]    O_ADDR,
	output logic      [LANES-1:0] O_LANE_WRITE_ENABLE_N,
	output logic      [DW-1:0]    O_D,
	// Memory read data and echo clock.
	input  wire logic [DW-1:0]    I_Q,
	input  wire logic             I_ECHO_TIMING_TRUE
);

	// Register state.
	logic [31:0]          ctrl_q;
	logic [AW-1:0]        addr_q;
	logic [DW-1:0]        wd0_q, wd1_q, rd0_q, rd1_q;
	logic [2*LANES-1:0]   be_q;
	logic                 wr_pend_q, rd_pend_q;
	logic [31:0]          rdata_q;
	// Sequencer and clock generator.
	sbc_pkg::sbc_state_t  state_q;
	logic [10:0]          cnt_q;
	logic [1:0]           div_q;
	logic                 phase_q;
	logic                 k_q, kn_q, c_q, cn_q, dll_disable_n_q;
	logic                 rsel_q, wsel_q;
	logic [AW-1:0]        oaddr_q;
	logic [LANES-1:0]     be_out_q;
	logic [DW-1:0]        d_q;
	// Read capture pipeline.
	logic [2:0]           rpipe_q;
	logic [1:0]           echo_sync_q;
	logic [DW-1:0]        q_s1_q, q_s2_q;
	logic                 wr_busy_q, rd_busy_q;
	logic                 relock_q;

	// Decodes.
	wire ready = (state_q == sbc_pkg::ST_READY);
	wire clocks_run = (state_q != sbc_pkg::ST_STOP);
	wire edge_now = clocks_run && (div_q == 2'(sbc_pkg::HALF_PERIOD - 1));
	wire k_rise = edge_now && !phase_q;
	wire kn_rise = edge_now && phase_q;
	// Pins move one cycle after a clock edge, so no rise ever meets a changing input.
	wire mid_phase = clocks_run && (div_q == 2'h0);
	wire set_low = mid_phase && !phase_q;
	wire set_high = mid_phase && phase_q;
	wire tied = ctrl_q[sbc_pkg::CTRL_ECHO_TIED];
	wire dll_en = ctrl_q[sbc_pkg::CTRL_DLL_EN];
	// A burst starts only where its select really stood at the true rise.
	wire start_wr = k_rise && !wsel_q;
	wire start_rd = k_rise && !rsel_q;
	wire go_wr = I_REG_WR && (I_REG_ADDR == sbc_pkg::REG_CTRL) && I_REG_WDATA[sbc_pkg::CTRL_WRITE_GO];
	wire go_rd = I_REG_WR && (I_REG_ADDR == sbc_pkg::REG_CTRL) && I_REG_WDATA[sbc_pkg::CTRL_READ_GO];
	wire go_rl = I_REG_WR && (I_REG_ADDR == sbc_pkg::REG_CTRL) && I_REG_WDATA[sbc_pkg::CTRL_RELOCK];
	wire [31:0] stat_word = {24'h0, echo_sync_q[1], rd_busy_q, wr_busy_q, rd_pend_q, wr_pend_q,
		state_q};

	// Read mux; unmapped offsets read zero.
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		unique case (I_REG_ADDR)
			sbc_pkg::REG_CTRL: rmux = ctrl_q;
			sbc_pkg::REG_STAT: rmux = stat_word;
			sbc_pkg::REG_ADDR: rmux = 32'(addr_q);
			sbc_pkg::REG_WD0:  rmux = 32'(wd0_q);
			sbc_pkg::REG_WD1:  rmux = 32'(wd1_q);
			sbc_pkg::REG_BE:   rmux = 32'(be_q);
			sbc_pkg::REG_RD0:  rmux = 32'(rd0_q);
			sbc_pkg::REG_RD1:  rmux = 32'(rd1_q);
			default:           rmux = 32'h0;
		endcase
	end

	// Register writes; a new go request wins over completion clearing.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			ctrl_q    <= sbc_pkg::CTRL_RESET;
			addr_q    <= '0;
			wd0_q     <= '0;
			wd1_q     <= '0;
			be_q      <= '1;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			relock_q  <= 1'b0;
			rdata_q   <= 32'h0;
		end else begin
			rdata_q <= I_REG_RD ? rmux : 32'h0;
			if (I_REG_WR && I_REG_ADDR == sbc_pkg::REG_CTRL) begin
				ctrl_q <= {26'h0, 3'b000, I_REG_WDATA[2:0]};
			end
			if (I_REG_WR && I_REG_ADDR == sbc_pkg::REG_ADDR) begin
				addr_q <= I_REG_WDATA[AW-1:0];
			end
			if (I_REG_WR && I_REG_ADDR == sbc_pkg::REG_WD0) begin
				wd0_q <= DW'(I_REG_WDATA);
			end
			if (I_REG_WR && I_REG_ADDR == sbc_pkg::REG_WD1) begin
				wd1_q <= DW'(I_REG_WDATA);
			end
			if (I_REG_WR && I_REG_ADDR == sbc_pkg::REG_BE) begin
				be_q <= I_REG_WDATA[2*LANES-1:0];
			end
			wr_pend_q <= go_wr || (wr_pend_q && !start_wr);
			rd_pend_q <= go_rd || (rd_pend_q && !start_rd);
			relock_q  <= go_rl || (relock_q && state_q != sbc_pkg::ST_STOP);
		end
	end

	// Start-up sequencer: count idle cycles of the memory clock; a relock stops the clocks first.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			state_q <= sbc_pkg::ST_OFF;
			cnt_q   <= '0;
			dll_disable_n_q  <= 1'b0;
		end else begin
			unique case (state_q)
				sbc_pkg::ST_OFF: begin
					dll_disable_n_q  <= dll_en;
					cnt_q   <= '0;
					state_q <= ctrl_q[sbc_pkg::CTRL_STOP_MODE] ? sbc_pkg::ST_STOP
						: sbc_pkg::ST_LOCK;
				end
				sbc_pkg::ST_STOP: begin
					// Clocks parked for the stop time before restarting.
					cnt_q <= cnt_q + 11'h1;
					// The park outlasts a running half period so the far side sees a real stop.
					if (cnt_q >= 11'(sbc_pkg::STOP_CYCLES + sbc_pkg::HALF_PERIOD - 1)) begin
						cnt_q   <= '0;
						state_q <= sbc_pkg::ST_LOCK;
					end
				end
				sbc_pkg::ST_LOCK: begin
					// Only idle cycles are issued while waiting for lock.
					if (k_rise) begin
						cnt_q <= cnt_q + 11'h1;
					end
					if (k_rise && cnt_q >= 11'(NOP_COUNT - 1)) begin
						state_q <= sbc_pkg::ST_READY;
					end
				end
				sbc_pkg::ST_READY: begin
					// A relock request stops the clocks and repeats the wait.
					if (relock_q) begin
						dll_disable_n_q  <= dll_en;
						cnt_q   <= '0;
						state_q <= sbc_pkg::ST_STOP;
					end
				end
				default: state_q <= sbc_pkg::ST_OFF;
			endcase
		end
	end

	// Clock divider; stopped clocks park K low, C low unless tied high, and complements high.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			div_q   <= '0;
			phase_q <= 1'b0;
			k_q     <= 1'b0;
			kn_q    <= 1'b1;
			c_q     <= 1'b0;
			cn_q    <= 1'b1;
		end else if (!clocks_run) begin
			div_q   <= '0;
			phase_q <= 1'b0;
			k_q     <= 1'b0;
			kn_q    <= 1'b1;
			c_q     <= tied;
			cn_q    <= 1'b1;
		end else begin
			div_q <= edge_now ? 2'h0 : div_q + 2'h1;
			if (edge_now) begin
				phase_q <= !phase_q;
				k_q     <= !phase_q;
				kn_q    <= phase_q;
				c_q     <= tied ? 1'b1 : !phase_q;
				cn_q    <= tied ? 1'b1 : phase_q;
			end
		end
	end

	// Command and data drive, changed in the middle of a half period for setup and hold.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			rsel_q   <= 1'b1;
			wsel_q   <= 1'b1;
			oaddr_q  <= '0;
			be_out_q <= '1;
			d_q      <= '0;
		end else if (set_low) begin
			// Selects and the first beat are set up for the next true rise.
			rsel_q   <= !(ready && rd_pend_q);
			wsel_q   <= !(ready && wr_pend_q);
			oaddr_q  <= addr_q;
			be_out_q <= (ready && wr_pend_q) ? be_q[LANES-1:0] : '1;
			d_q      <= wd0_q;
		end else if (set_high && wr_busy_q) begin
			// Second beat with its own lane pattern.
			be_out_q <= be_q[2*LANES-1:LANES];
			d_q      <= wd1_q;
		end
	end

	// Burst tracking and read capture of two words after the read edge.
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			wr_busy_q   <= 1'b0;
			rd_busy_q   <= 1'b0;
			rpipe_q     <= '0;
			echo_sync_q <= '0;
			q_s1_q      <= '0;
			q_s2_q      <= '0;
			rd0_q       <= '0;
			rd1_q       <= '0;
		end else begin
			echo_sync_q <= {echo_sync_q[0], I_ECHO_TIMING_TRUE};
			q_s1_q      <= I_Q;
			q_s2_q      <= q_s1_q;
			if (start_wr) begin
				wr_busy_q <= 1'b1;
			end else if (kn_rise) begin
				wr_busy_q <= 1'b0;
			end
			if (start_rd) begin
				rd_busy_q <= 1'b1;
			end else if (set_low && rpipe_q[2] && rpipe_q[1:0] == 2'b00) begin
				rd_busy_q <= 1'b0;
			end
			// One bit per true rise; back-to-back reads each keep their own slot.
			if (k_rise) begin
				rpipe_q <= {rpipe_q[1:0], start_rd};
			end
			// Word 0 lands at the complement rise of t+1 and word 1 at the true rise of t+2;
			// the two-stage sync shows each of them one half period later.
			if (set_high && rpipe_q[2]) begin
				rd0_q <= q_s2_q;
			end
			if (set_low && rpipe_q[2]) begin
				rd1_q <= q_s2_q;
			end
		end
	end

	// Outputs straight from flip-flops.
	assign O_REG_RDATA           = rdata_q;
	assign O_K                   = k_q;
	assign O_K_N                 = kn_q;
	assign O_C                   = c_q;
	assign O_C_N                 = cn_q;
	assign O_DLL_DISABLE_N       = dll_disable_n_q;
	assign O_READ_SEL_N          = rsel_q;
	assign O_WRITE_SEL_N         = wsel_q;
	assign O_ADDR                = oaddr_q;
	assign O_LANE_WRITE_ENABLE_N = be_out_q;
	assign O_D                   = d_q;

endmodule

`default_nettype wire

// ### core/sbc_pkg.sv
// Package with constants and types for the burst SRAM port controller.
package sbc_pkg;

	// Minimum idle cycles after power-up, clock stop or relock.
	localparam int NOP_CYCLES = 1024;
	// Minimum clock stop time in ns.
	localparam int STOP_TIME_NS = 30;
	// System clock period in ns.
	localparam int CLK_PERIOD_NS = 50;
	// Stop time expressed in system cycles, rounded up, at least one.
	localparam int STOP_CYCLES_RAW = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STOP_CYCLES = (STOP_CYCLES_RAW < 1) ? 1 : STOP_CYCLES_RAW;
	// Half period of the generated memory clock in system cycles.
	localparam int HALF_PERIOD = 2;
	// Register offsets of the controller's own command port.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [3:0] REG_ADDR = 4'h2;
	localparam logic [3:0] REG_WD0 = 4'h3;
	localparam logic [3:0] REG_WD1 = 4'h4;
	localparam logic [3:0] REG_BE = 4'h5;
	localparam logic [3:0] REG_RD0 = 4'h6;
	localparam logic [3:0] REG_RD1 = 4'h7;
	// Control register field positions.
	localparam int CTRL_DLL_EN = 0;
	localparam int CTRL_STOP_MODE = 1;
	localparam int CTRL_ECHO_TIED = 2;
	localparam int CTRL_WRITE_GO = 3;
	localparam int CTRL_READ_GO = 4;
	localparam int CTRL_RELOCK = 5;
	// Control register reset value.
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Sequencer states, Gray coded along the path ST_OFF, ST_STOP, ST_LOCK, ST_READY.
	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_STOP  = 3'b001,
		ST_LOCK  = 3'b011,
		ST_READY = 3'b010
	} sbc_state_t;

endpackage

// ### verification/sbc_props.sv
// Concurrent checks on the pins of the burst SRAM port controller.
`timescale 1ns/10ps
`default_nettype none
module sbc_props #(
	parameter int DW = 36,
	parameter int LANES = 4,
	parameter int NOP_COUNT = 1024
) (
	input wire logic             I_CLK,
	input wire logic             I_RESET,
	input wire logic             O_K,
	input wire logic             O_K_N,
	input wire logic             O_C,
	input wire logic             O_C_N,
	input wire logic             O_READ_SEL_N,
	input wire logic             O_WRITE_SEL_N,
	input wire logic [LANES-1:0] O_LANE_WRITE_ENABLE_N,
	input wire logic [DW-1:0]    O_D
);
	int unsigned nops_q;
	// True clock rises since reset or a stop; three low samples mark a stop.
	always_ff @(posedge I_CLK) begin
		if (I_RESET || (!O_K && !$past(O_K) && !$past(O_K, 2)))
			nops_q <= 0;
		else if (O_K && !$past(O_K) && nops_q < 4096)
			nops_q <= nops_q + 1;
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RESET);
	a_sel_at_kn: assert property (($changed(O_READ_SEL_N) || $changed(O_WRITE_SEL_N))
		|-> O_K_N && $past(O_K_N) && !$past(O_K_N, 2))
		else $error("select moved outside the middle of the complement phase");
	a_clk_pair: assert property (O_K != O_K_N) else $error("clock pair not complementary");
	a_wr_beat0: assert property ($fell(O_WRITE_SEL_N) |-> ##1 $rose(O_K))
		else $error("write select not ahead of true rise");
	a_d_on_edges: assert property ($changed(O_D) |-> $stable(O_K) && $past(O_K) != $past(O_K, 2))
		else $error("write data moved next to a clock rise");
	a_be_in_write: assert property (!(&O_LANE_WRITE_ENABLE_N) |-> !O_WRITE_SEL_N
		|| !$past(O_WRITE_SEL_N) || !$past(O_WRITE_SEL_N, 2)) else $error("lane enable outside write");
	a_park_low: assert property ($stable(O_K) [*3] |-> !O_K) else $error("stopped clock not parked");
	a_stop_c_low: assert property ($stable(O_K) [*3] ##0 !(O_C && O_C_N) |-> !O_C)
		else $error("output clock high during stop");
	a_nop_first: assert property (!O_READ_SEL_N || !O_WRITE_SEL_N |-> nops_q >= NOP_COUNT)
		else $error("select before idle cycles done");
	a_rd_hold: assert property ($fell(O_READ_SEL_N) |-> !O_READ_SEL_N [*4])
		else $error("read select too short");
	c_read: cover property ($fell(O_READ_SEL_N));
	c_write: cover property ($fell(O_WRITE_SEL_N));
	c_tied: cover property (O_C && O_C_N);
endmodule
bind sbc_ctrl sbc_props #(.DW(DW), .LANES(LANES), .NOP_COUNT(NOP_COUNT)) u_props (
	.I_CLK(I_CLK), .I_RESET(I_RESET), .O_K(O_K), .O_K_N(O_K_N), .O_C(O_C), .O_C_N(O_C_N),
	.O_READ_SEL_N(O_READ_SEL_N), .O_WRITE_SEL_N(O_WRITE_SEL_N),
	.O_LANE_WRITE_ENABLE_N(O_LANE_WRITE_ENABLE_N), .O_D(O_D));
`default_nettype wire

// ### verification/sbc_mem.sv
// Behavioural model of the two-word burst SRAM.
`timescale 1ns/10ps
`default_nettype none
module sbc_mem #(
	parameter int DW = 18,
	parameter int AW = 20,
	parameter int LANES = 2
) (
	input  wire logic             i_k,
	input  wire logic             i_k_n,
	input  wire logic             i_c,
	input  wire logic             i_c_n,
	input  wire logic             i_rsel_n,
	input  wire logic             i_wsel_n,
	input  wire logic [AW-1:0]    i_addr,
	input  wire logic [LANES-1:0] i_bw_n,
	input  wire logic [DW-1:0]    i_d,
	output logic      [DW-1:0]    o_q,
	output logic                  o_echo
);
	logic [DW-1:0] mem [0:15];
	logic [2:0]    wa, ra1, ra2, rq;
	logic          wp, r1, r2, h;
	// Tied-high output clocks hand read timing to the input clocks.
	wire tie = i_c && i_c_n;
	wire ck = tie ? i_k : i_c;
	wire ckn = tie ? i_k_n : i_c_n;
	assign o_echo = ck;
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, n, input logic [LANES-1:0] e);
		for (int i = 0; i < LANES; i++)
			if (!e[i])
				o[9*i +: 9] = n[9*i +: 9];
		return o;
	endfunction
	initial begin
		{wp, r1, r2, h, o_q} = '0;
		for (int i = 0; i < 16; i++)
			mem[i] = '0;
	end
	// Selects and beat 0 are taken at the true rise; a stopped clock freezes all.
	always @(posedge i_k) begin
		wp <= !i_wsel_n;
		if (!i_wsel_n) begin
			wa <= i_addr[2:0];
			mem[{i_addr[2:0], 1'h0}] <= merge(mem[{i_addr[2:0], 1'h0}], i_d, i_bw_n);
		end
		r1 <= !i_rsel_n;
		ra1 <= i_addr[2:0];
		r2 <= r1;
		ra2 <= ra1;
	end
	// Beat 1 of a write lands at the complement rise.
	always @(posedge i_k_n)
		if (wp)
			mem[{wa, 1'h1}] <= merge(mem[{wa, 1'h1}], i_d, i_bw_n);
	// Idle data toggle instead of floating, so stale words never look valid.
	always @(posedge ck or posedge ckn)
		if (ckn) begin
			h <= r2;
			rq <= ra2;
			o_q <= r2 ? mem[{ra2, 1'h0}] : ~o_q;
		end else
			o_q <= h ? mem[{rq, 1'h1}] : ~o_q;
endmodule
`default_nettype wire

// ### verification/sbc_tb.sv
// Self-checking bench for the burst SRAM port controller.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
	logic        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0;
	logic [3:0]  ra = 4'h0;
	logic [31:0] wd = 32'h0, rdata, rv, ctl = 32'h0;
	logic        k, kn, c, cn, dll_n, rs_n, ws_n, echo;
	logic [19:0] addr;
	logic [1:0]  bw_n;
	logic [17:0] d, q;
	int          errors = 0, comparisons = 0;
	always #25 clk = ~clk;
	sbc_ctrl #(.DW(18), .LANES(2), .NOP_COUNT(8)) dut (.I_CLK(clk), .I_RESET(rst),
		.I_REG_ADDR(ra), .I_REG_WDATA(wd), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
		.O_K(k), .O_K_N(kn), .O_C(c), .O_C_N(cn), .O_DLL_DISABLE_N(dll_n), .O_READ_SEL_N(rs_n),
		.O_WRITE_SEL_N(ws_n), .O_ADDR(addr), .O_LANE_WRITE_ENABLE_N(bw_n), .O_D(d), .I_Q(q),
		.I_ECHO_TIMING_TRUE(echo));
	sbc_mem u_mem (.i_k(k), .i_k_n(kn), .i_c(c), .i_c_n(cn),
		.i_rsel_n(rs_n), .i_wsel_n(ws_n), .i_addr(addr), .i_bw_n(bw_n), .i_d(d), .o_q(q),
		.o_echo(echo));
	task automatic conclude();
		if (errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Each access waits an edge first, so a strobe is never lowered and raised together.
	task automatic wreg(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		ra <= a;
		wd <= v;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk);
		ra <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 v = rdata;
	endtask
	// Poll until ready with nothing pending or busy.
	task automatic settle();
		for (int i = 0; i < 300; i++) begin
			rreg(sbc_pkg::REG_STAT, rv);
			if (rv[6:0] === 7'h02)
				return;
		end
		errors++;
		conclude();
	endtask
	task automatic t_reset();
		`CHK(dll_n, 1'h0)
		rreg(sbc_pkg::REG_STAT, rv);
		`CHK(rv[2:0], 3'h3)
		rreg(sbc_pkg::REG_BE, rv);
		`CHK(rv[3:0], 4'hf)
		wreg(4'h9, 32'h1234_5678);
		rreg(4'h9, rv);
		`CHK(rv, 32'h0)
		settle();
	endtask
	task automatic t_burst(input logic [31:0] a, w0, w1, be, e0, e1);
		wreg(sbc_pkg::REG_WD0, w0);
		wreg(sbc_pkg::REG_WD1, w1);
		wreg(sbc_pkg::REG_BE, be);
		wreg(sbc_pkg::REG_ADDR, a);
		wreg(sbc_pkg::REG_CTRL, ctl | 32'h08);
		settle();
		wreg(sbc_pkg::REG_CTRL, ctl | 32'h10);
		settle();
		rreg(sbc_pkg::REG_RD0, rv);
		`CHK(rv[17:0], e0[17:0])
		rreg(sbc_pkg::REG_RD1, rv);
		`CHK(rv[17:0], e1[17:0])
	endtask
	task automatic t_relock(input logic [31:0] v);
		ctl = v;
		wreg(sbc_pkg::REG_CTRL, v | 32'h20);
		rreg(sbc_pkg::REG_STAT, rv);
		`CHK(rv[2:0] === 3'h2, 1'h0)
		settle();
		`CHK(dll_n, v[0])
		`CHK(c && cn, v[2])
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_burst(32'h3, 32'h1f0f0, 32'h0abcd, 32'h0, 32'h1f0f0, 32'h0abcd);
		t_burst(32'h3, 32'h3ffff, 32'h3ffff, 32'h6, 32'h1f1ff, 32'h3ffcd);
		t_burst(32'h3, 32'h0, 32'h0, 32'hf, 32'h1f1ff, 32'h3ffcd);
		t_relock(32'h1);
		t_burst(32'h4, 32'h12345, 32'h2aaaa, 32'h0, 32'h12345, 32'h2aaaa);
		t_relock(32'h5);
		t_burst(32'h5, 32'h15555, 32'h0f00f, 32'h0, 32'h15555, 32'h0f00f);
		conclude();
	end
endmodule
`default_nettype wire
